// ===== uart_pins_pkg.sv
// Constants shared by the dual-channel modem and serial pin block.
// Assumes one 250 MHz system clock and a plain strobe register port.
package uart_pins_pkg;

    localparam int NUM_CH = 2;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int REG_W  = 3;

    // Register index inside a channel; address bit 3 selects the channel
    localparam logic [REG_W-1:0] REG_MODEM_CTL = 3'h0;
    localparam logic [REG_W-1:0] REG_FLOW_CTL  = 3'h1;
    localparam logic [REG_W-1:0] REG_EVT_EN    = 3'h2;
    localparam logic [REG_W-1:0] REG_MODEM_ST  = 3'h3;
    localparam logic [REG_W-1:0] REG_IRQ_STAT  = 3'h4;
    localparam logic [REG_W-1:0] REG_IRQ_MASK  = 3'h5;
    localparam logic [REG_W-1:0] REG_BAUD_DIV  = 3'h6;
    localparam int               CH_SEL_BIT    = 3;

    // Modem control fields
    localparam int MC_DTR_BIT    = 0;
    localparam int MC_RTS_BIT    = 1;
    localparam int MC_IRQ_OE_BIT = 3;
    localparam int MC_IR_SEL_BIT = 6;

    // Flow control and event enable fields
    localparam int FC_AUTO_RTS_BIT = 6;
    localparam int FC_AUTO_CTS_BIT = 7;
    localparam int EE_RTS_IRQ_BIT  = 6;
    localparam int EE_CTS_IRQ_BIT  = 7;

    // Event, status and level bit order
    localparam int EV_CTS = 0;
    localparam int EV_DSR = 1;
    localparam int EV_RI  = 2;
    localparam int EV_CD  = 3;
    localparam int EV_RTS = 4;
    localparam int EV_W   = 5;

    // Synchronised pin order inside a channel
    localparam int PIN_RX  = 0;
    localparam int PIN_CTS = 1;
    localparam int PIN_DSR = 2;
    localparam int PIN_CD  = 3;
    localparam int PIN_RI  = 4;
    localparam int PIN_W   = 5;

    // Reset values
    localparam logic [DATA_W-1:0] MODEM_CTL_RST = 8'h00;
    localparam logic [DATA_W-1:0] FLOW_CTL_RST  = 8'h00;
    localparam logic [DATA_W-1:0] EVT_EN_RST    = 8'h00;
    localparam logic [DATA_W-1:0] IRQ_MASK_RST  = 8'h00;
    localparam logic [DATA_W-1:0] BAUD_DIV_RST  = 8'h01;
    localparam logic [PIN_W-1:0]  PIN_IDLE      = 5'h1f;
    localparam logic [EV_W-1:0]   LVL_IDLE      = 5'h1f;

    // Infrared cell: a zero bit is a short high pulse inside 16 ticks
    localparam int              IR_CNT_W       = 5;
    localparam logic [3:0]      IR_PULSE_START = 4'h6;
    localparam logic [3:0]      IR_PULSE_END   = 4'h9;
    localparam logic [IR_CNT_W-1:0] IR_CELL_TICKS = 5'h10;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_MIN_NS  = 40;
    localparam int RESET_MIN_CYC =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== pin_channel.sv
// One channel's pin front end: input synchronisers, standard or infrared
// transmit shaping and infrared receive pulse stretching.
// Assumes tick16_i is a one-cycle enable at sixteen times the bit rate.
`timescale 1ns/10ps
module pin_channel
    import uart_pins_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             tick16_i,
    input  wire logic             ir_sel_i,
    input  wire logic             tx_bit_i,
    input  wire logic             tx_active_i,
    input  wire logic [PIN_W-1:0] pins_n_i,
    output logic      [PIN_W-1:0] pins_s_o,
    output logic                  serial_out_o,
    output logic                  rx_bit_o
);

    typedef struct packed {
        logic [PIN_W-1:0]    s1;
        logic [PIN_W-1:0]    s2;
        logic                rx_prev;
        logic [3:0]          tx_cnt;
        logic [IR_CNT_W-1:0] rx_cnt;
        logic                serial_out;
        logic                rx_bit;
    } chan_state_t;

    chan_state_t q;
    chan_state_t n;

    always_comb begin
        n = q;
        n.s1 = pins_n_i;
        n.s2 = q.s1;
        // Transmit: idle high in standard mode, idle low when infrared
        if (!tx_active_i) begin
            n.tx_cnt = 4'h0;
            n.serial_out = !ir_sel_i;
        end else begin
            if (tick16_i) begin
                n.tx_cnt = q.tx_cnt + 4'h1;
            end
            if (ir_sel_i) begin
                n.serial_out = !tx_bit_i && (q.tx_cnt >= IR_PULSE_START)
                               && (q.tx_cnt < IR_PULSE_END);
            end else begin
                n.serial_out = tx_bit_i;
            end
        end
        // Receive: a rising infrared pulse reads as one zero bit cell
        n.rx_prev = q.s2[PIN_RX];
        if (ir_sel_i) begin
            if (q.s2[PIN_RX] && !q.rx_prev) begin
                n.rx_cnt = IR_CELL_TICKS;
            end else if (tick16_i && q.rx_cnt != '0) begin
                n.rx_cnt = q.rx_cnt - 5'h01;
            end
            n.rx_bit = (n.rx_cnt == '0);
        end else begin
            n.rx_cnt = '0;
            n.rx_bit = q.s2[PIN_RX];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q.s1 <= PIN_IDLE;
            q.s2 <= PIN_IDLE;
            q.rx_prev <= 1'b1;
            q.tx_cnt <= 4'h0;
            q.rx_cnt <= '0;
            q.serial_out <= 1'b1;
            q.rx_bit <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign pins_s_o = q.s2;
    assign serial_out_o = q.serial_out;
    assign rx_bit_o = q.rx_bit;

endmodule

// ===== uart_modem_serial_pins.sv
// Dual-channel modem and serial pin block with its control registers,
// modem event interrupts and per-channel bit-rate tick dividers.
// Assumes the UART core shares sys_clk_i and supplies bit streams.
`timescale 1ns/10ps
// Function
// - Infrared select clear: plain serial path, transmit idles high.
// - Infrared select set: encode and decode infrared pulses, idle level low.
// - Interrupt output enable set: drive interrupt pin, spare output low.
// - Enable clear, the default: interrupt pin floats, spare output high.
// - Clear-to-send acts as auto flow input when enabled, else plain input.
// - Set-ready, carrier and ring inputs never affect transfer or flow.
// - Terminal-ready output is a software driven handshake or plain level.
// - Receiver-ready output, active low, follows receive buffer status.
// - Reset clears registers but sets the divisor to one, idles outputs; transmit high, receive ignored.
module uart_modem_serial_pins
    import uart_pins_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_n_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    output logic                   irq_o,
    // Core side, channel A
    input  wire logic              tx_bit_a_i,
    input  wire logic              tx_active_a_i,
    input  wire logic              rx_has_data_a_i,
    input  wire logic              rx_above_trig_a_i,
    output logic                   rx_bit_a_o,
    output logic                   tx_hold_a_o,
    output logic                   tick16_a_o,
    // Core side, channel B
    input  wire logic              tx_bit_b_i,
    input  wire logic              tx_active_b_i,
    input  wire logic              rx_has_data_b_i,
    input  wire logic              rx_above_trig_b_i,
    output logic                   rx_bit_b_o,
    output logic                   tx_hold_b_o,
    output logic                   tick16_b_o,
    // Pins, channel A
    output logic                   serial_out_a_o,
    input  wire logic              serial_in_a_i,
    output logic                   request_to_send_n_a_o,
    input  wire logic              clear_to_send_n_a_i,
    output logic                   terminal_ready_n_a_o,
    input  wire logic              set_ready_n_a_i,
    input  wire logic              carrier_detect_n_a_i,
    input  wire logic              ring_indicator_n_a_i,
    output logic                   spare_output_n_a_o,
    output logic                   irq_out_a_o,
    output logic                   irq_out_a_oe_o,
    output logic                   rx_ready_n_a_o,
    // Pins, channel B
    output logic                   serial_out_b_o,
    input  wire logic              serial_in_b_i,
    output logic                   request_to_send_n_b_o,
    input  wire logic              clear_to_send_n_b_i,
    output logic                   terminal_ready_n_b_o,
    input  wire logic              set_ready_n_b_i,
    input  wire logic              carrier_detect_n_b_i,
    input  wire logic              ring_indicator_n_b_i,
    output logic                   spare_output_n_b_o,
    output logic                   irq_out_b_o,
    output logic                   irq_out_b_oe_o,
    output logic                   rx_ready_n_b_o
);

    typedef struct packed {
        logic [NUM_CH-1:0][DATA_W-1:0] mctl;
        logic [NUM_CH-1:0][DATA_W-1:0] fctl;
        logic [NUM_CH-1:0][DATA_W-1:0] een;
        logic [NUM_CH-1:0][DATA_W-1:0] imask;
        logic [NUM_CH-1:0][DATA_W-1:0] div;
        logic [NUM_CH-1:0][DATA_W-1:0] divcnt;
        logic [NUM_CH-1:0][EV_W-1:0]   ista;
        logic [NUM_CH-1:0][EV_W-1:0]   lvl;
        logic [NUM_CH-1:0]             tick;
        logic [NUM_CH-1:0]             rts_n;
        logic [NUM_CH-1:0]             dtr_n;
        logic [NUM_CH-1:0]             rx_rdy_n;
        logic [NUM_CH-1:0]             tx_hold;
        logic [NUM_CH-1:0]             irq_pin;
        logic                          irq;
        logic [DATA_W-1:0]             rdata;
    } state_t;

    state_t q;
    state_t n;

    // Per-channel views of the ports
    logic [NUM_CH-1:0]            tx_bit;
    logic [NUM_CH-1:0]            tx_active;
    logic [NUM_CH-1:0]            rx_has_data;
    logic [NUM_CH-1:0]            rx_above_trig;
    logic [NUM_CH-1:0]            rx_bit;
    logic [NUM_CH-1:0]            serial_out;
    logic [NUM_CH-1:0][PIN_W-1:0] pins_n;
    logic [NUM_CH-1:0][PIN_W-1:0] pins_s;

    assign tx_bit        = {tx_bit_b_i, tx_bit_a_i};
    assign tx_active     = {tx_active_b_i, tx_active_a_i};
    assign rx_has_data   = {rx_has_data_b_i, rx_has_data_a_i};
    assign rx_above_trig = {rx_above_trig_b_i, rx_above_trig_a_i};
    assign pins_n[0] = {ring_indicator_n_a_i, carrier_detect_n_a_i,
                        set_ready_n_a_i, clear_to_send_n_a_i, serial_in_a_i};
    assign pins_n[1] = {ring_indicator_n_b_i, carrier_detect_n_b_i,
                        set_ready_n_b_i, clear_to_send_n_b_i, serial_in_b_i};

    // One front end per channel, nothing shared between them
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            pin_channel u_pin (
                .sys_clk_i    (sys_clk_i),
                .reset_n_i    (reset_n_i),
                .tick16_i     (q.tick[ch]),
                .ir_sel_i     (q.mctl[ch][MC_IR_SEL_BIT]),
                .tx_bit_i     (tx_bit[ch]),
                .tx_active_i  (tx_active[ch]),
                .pins_n_i     (pins_n[ch]),
                .pins_s_o     (pins_s[ch]),
                .serial_out_o (serial_out[ch]),
                .rx_bit_o     (rx_bit[ch])
            );
        end
    endgenerate

    logic                  sel_ch;
    logic [REG_W-1:0]      sel_reg;

    assign sel_ch  = addr_i[CH_SEL_BIT];
    assign sel_reg = addr_i[REG_W-1:0];

    always_comb begin
        logic [EV_W-1:0]   cur;
        logic [EV_W-1:0]   chg;
        logic [EV_W-1:0]   set;
        logic [EV_W-1:0]   clr;
        logic [DATA_W-1:0] stat;
        logic              hit;
        cur  = '0;
        chg  = '0;
        set  = '0;
        clr  = '0;
        stat = '0;
        hit  = 1'b0;
        n = q;
        n.irq = 1'b0;
        n.rdata = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            hit = (sel_ch == c[0]);
            // Bit-rate tick; a divisor of zero acts as one
            if (q.divcnt[c] <= 8'h01) begin
                n.divcnt[c] = q.div[c];
                n.tick[c] = 1'b1;
            end else begin
                n.divcnt[c] = q.divcnt[c] - 8'h01;
                n.tick[c] = 1'b0;
            end
            // Register writes
            clr = '0;
            if (wr_i && hit) begin
                unique case (sel_reg)
                    REG_MODEM_CTL: n.mctl[c] = wdata_i;
                    REG_FLOW_CTL:  n.fctl[c] = wdata_i;
                    REG_EVT_EN:    n.een[c] = wdata_i;
                    REG_IRQ_STAT:  clr = wdata_i[EV_W-1:0];
                    REG_IRQ_MASK:  n.imask[c] = wdata_i;
                    REG_BAUD_DIV:  n.div[c] = wdata_i;
                    default:       clr = '0;
                endcase
            end
            // Outputs driven from software bits
            n.dtr_n[c] = !q.mctl[c][MC_DTR_BIT];
            if (q.fctl[c][FC_AUTO_RTS_BIT] && rx_above_trig[c]) begin
                n.rts_n[c] = 1'b1;
            end else begin
                n.rts_n[c] = !q.mctl[c][MC_RTS_BIT];
            end
            // Only clear-to-send may stall the transmitter
            n.tx_hold[c] = q.fctl[c][FC_AUTO_CTS_BIT]
                           && pins_s[c][PIN_CTS];
            n.rx_rdy_n[c] = !rx_has_data[c];
            // Modem line change events, set beats clear
            cur = {q.rts_n[c], pins_s[c][PIN_CD], pins_s[c][PIN_RI],
                   pins_s[c][PIN_DSR], pins_s[c][PIN_CTS]};
            n.lvl[c] = cur;
            chg = cur ^ q.lvl[c];
            set = chg;
            set[EV_CTS] = chg[EV_CTS] && q.een[c][EE_CTS_IRQ_BIT];
            set[EV_RTS] = chg[EV_RTS] && q.een[c][EE_RTS_IRQ_BIT];
            n.ista[c] = (q.ista[c] & ~clr) | set;
            n.irq_pin[c] = |(q.ista[c] & ~q.imask[c][EV_W-1:0]);
            n.irq = n.irq | n.irq_pin[c];
            // Register reads, data stand one cycle
            stat = {3'h0, ~cur};
            if (rd_i && hit) begin
                unique case (sel_reg)
                    REG_MODEM_CTL: n.rdata = q.mctl[c];
                    REG_FLOW_CTL:  n.rdata = q.fctl[c];
                    REG_EVT_EN:    n.rdata = q.een[c];
                    REG_MODEM_ST:  n.rdata = stat;
                    REG_IRQ_STAT:  n.rdata = {3'h0, q.ista[c]};
                    REG_IRQ_MASK:  n.rdata = q.imask[c];
                    REG_BAUD_DIV:  n.rdata = q.div[c];
                    default:       n.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q.mctl <= {NUM_CH{MODEM_CTL_RST}};
            q.fctl <= {NUM_CH{FLOW_CTL_RST}};
            q.een <= {NUM_CH{EVT_EN_RST}};
            q.imask <= {NUM_CH{IRQ_MASK_RST}};
            q.div <= {NUM_CH{BAUD_DIV_RST}};
            q.divcnt <= {NUM_CH{BAUD_DIV_RST}};
            q.ista <= '0;
            q.lvl <= {NUM_CH{LVL_IDLE}};
            q.tick <= '0;
            q.rts_n <= '1;
            q.dtr_n <= '1;
            q.rx_rdy_n <= '1;
            q.tx_hold <= '0;
            q.irq_pin <= '0;
            q.irq <= 1'b0;
            q.rdata <= '0;
        end else begin
            q <= n;
        end
    end

    // Interrupt pin and spare output share one enable bit
    assign irq_out_a_o    = q.irq_pin[0];
    assign irq_out_a_oe_o = q.mctl[0][MC_IRQ_OE_BIT];
    assign spare_output_n_a_o = !q.mctl[0][MC_IRQ_OE_BIT];
    assign irq_out_b_o    = q.irq_pin[1];
    assign irq_out_b_oe_o = q.mctl[1][MC_IRQ_OE_BIT];
    assign spare_output_n_b_o = !q.mctl[1][MC_IRQ_OE_BIT];

    assign serial_out_a_o = serial_out[0];
    assign serial_out_b_o = serial_out[1];
    assign rx_bit_a_o = rx_bit[0];
    assign rx_bit_b_o = rx_bit[1];
    assign request_to_send_n_a_o = q.rts_n[0];
    assign request_to_send_n_b_o = q.rts_n[1];
    assign terminal_ready_n_a_o = q.dtr_n[0];
    assign terminal_ready_n_b_o = q.dtr_n[1];
    assign rx_ready_n_a_o = q.rx_rdy_n[0];
    assign rx_ready_n_b_o = q.rx_rdy_n[1];
    assign tx_hold_a_o = q.tx_hold[0];
    assign tx_hold_b_o = q.tx_hold[1];
    assign tick16_a_o = q.tick[0];
    assign tick16_b_o = q.tick[1];
    assign rdata_o = q.rdata;
    assign irq_o = q.irq;

endmodule

// ===== uart_modem_serial_pins_sva.sv
// Checker for the dual pin block, watching only its top-level ports.
// Assumes the register writes seen on the port are the only control path.
`timescale 1ns/10ps
module uart_modem_serial_pins_sva
    import uart_pins_pkg::*;
(
    input wire logic sys_clk_i, reset_n_i, wr_i, tx_bit_a_i, tx_active_a_i,
    input wire logic rx_has_data_a_i, tx_hold_a_o, clear_to_send_n_a_i,
    input wire logic serial_out_a_o, serial_out_b_o, terminal_ready_n_a_o,
    input wire logic spare_output_n_a_o, irq_out_a_oe_o, rx_ready_n_a_o,
    input wire logic irq_o,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i
);
    // Shadow of channel A control, so mode-dependent rules know the mode
    logic [DATA_W-1:0] mc_r, fc_r;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mc_r <= MODEM_CTL_RST;
            fc_r <= FLOW_CTL_RST;
        end else if (wr_i) begin
            if (addr_i == {1'b0, REG_MODEM_CTL}) mc_r <= wdata_i;
            if (addr_i == {1'b0, REG_FLOW_CTL}) fc_r <= wdata_i;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_spare_inv: assert property (spare_output_n_a_o ^ irq_out_a_oe_o)
        else $error("spare output not inverse of interrupt enable");
    a_oe_ctl: assert property (irq_out_a_oe_o == mc_r[MC_IRQ_OE_BIT])
        else $error("interrupt enable does not follow control bit");
    a_tx_idle_high: assert property (!mc_r[MC_IR_SEL_BIT] &&
        !$past(mc_r[MC_IR_SEL_BIT]) && !$past(tx_active_a_i) |-> serial_out_a_o)
        else $error("standard transmit not idle high");
    a_tx_follows: assert property ($past(reset_n_i) &&
        !mc_r[MC_IR_SEL_BIT] && !$past(mc_r[MC_IR_SEL_BIT]) &&
        $past(tx_active_a_i) |-> serial_out_a_o == $past(tx_bit_a_i))
        else $error("standard transmit does not carry the bit");
    a_ir_idle_low: assert property (mc_r[MC_IR_SEL_BIT] &&
        $past(mc_r[MC_IR_SEL_BIT]) && !$past(tx_active_a_i) |-> !serial_out_a_o)
        else $error("infrared transmit not idle low");
    a_reset_outs: assert property ($rose(reset_n_i) |-> serial_out_a_o &&
        serial_out_b_o && terminal_ready_n_a_o && rx_ready_n_a_o && !irq_o)
        else $error("outputs not at reset level");
    a_rx_ready: assert property ($past(reset_n_i) |->
        rx_ready_n_a_o == !$past(rx_has_data_a_i))
        else $error("receiver ready does not follow buffer state");
    a_dtr_level: assert property ($past(reset_n_i) |->
        terminal_ready_n_a_o == !$past(mc_r[MC_DTR_BIT]))
        else $error("terminal ready does not follow control bit");
    a_cts_holds: assert property (
        (fc_r[FC_AUTO_CTS_BIT] && clear_to_send_n_a_i)[*4] |=> tx_hold_a_o)
        else $error("auto flow does not hold transmit");
    a_cts_plain: assert property (!fc_r[FC_AUTO_CTS_BIT] &&
        !$past(fc_r[FC_AUTO_CTS_BIT]) |-> !tx_hold_a_o)
        else $error("transmit held with auto flow off");
    c_ir_pulse: cover property (mc_r[MC_IR_SEL_BIT] && serial_out_a_o);
    c_tx_held: cover property (tx_hold_a_o);
    c_irq: cover property (irq_o && irq_out_a_oe_o);
endmodule
bind uart_modem_serial_pins uart_modem_serial_pins_sva chk (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wr_i(wr_i),
    .tx_bit_a_i(tx_bit_a_i), .tx_active_a_i(tx_active_a_i),
    .rx_has_data_a_i(rx_has_data_a_i), .tx_hold_a_o(tx_hold_a_o),
    .clear_to_send_n_a_i(clear_to_send_n_a_i),
    .serial_out_a_o(serial_out_a_o), .serial_out_b_o(serial_out_b_o),
    .terminal_ready_n_a_o(terminal_ready_n_a_o),
    .spare_output_n_a_o(spare_output_n_a_o),
    .irq_out_a_oe_o(irq_out_a_oe_o), .rx_ready_n_a_o(rx_ready_n_a_o),
    .irq_o(irq_o), .addr_i(addr_i), .wdata_i(wdata_i)
);

// ===== line_partner.sv
// Far-side model: serial line with loopback and modem status lines.
// Assumes the bench commands loop, lag and the asserted modem lines.
`timescale 1ns/10ps
module line_partner (
    input  wire logic       sys_clk_i,
    input  wire logic       line_i,
    input  wire logic       loop_i,
    input  wire logic [1:0] lag_i,
    input  wire logic [3:0] assert_i,
    output logic            line_o,
    output logic [3:0]      modem_n_o
);
    logic [3:0] dly_r;
    always_ff @(posedge sys_clk_i) begin
        dly_r <= {dly_r[2:0], line_i};
    end
    // Lag selects a prompt or slow echo; unused line is pulled high
    assign line_o = loop_i ? dly_r[lag_i] : 1'b1;
    // Order: clear-to-send, set-ready, ring, carrier; all active low
    assign modem_n_o = ~assert_i;
endmodule

// ===== uart_modem_serial_pins_tb.sv
// Self-checking bench for the dual pin block with a partner per channel.
// Assumes the design package and the line partner model are compiled.
`timescale 1ns/10ps
module uart_modem_serial_pins_tb
    import uart_pins_pkg::*;
;
    logic sys_clk_i, reset_n_i, wr_i, rd_i, irq_o, tx_bit_a_i, tx_active_a_i;
    logic rx_has_data_a_i, rx_above_trig_a_i, rx_bit_a_o, tx_hold_a_o;
    logic b_bit, b_act, b_has, b_trig, serial_in_a_i, serial_in_b_i, loop_a;
    logic serial_out_a_o, serial_out_b_o, request_to_send_n_a_o, irq_out_a_o;
    logic terminal_ready_n_a_o, spare_output_n_a_o, spare_output_n_b_o;
    logic irq_out_a_oe_o, irq_out_b_oe_o, rx_ready_n_a_o, rx_ready_n_b_o;
    logic [1:0]        lag_a;
    logic [3:0]        ma, ma_n, mb_n;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o;
    int                n_errors, comparisons;

    uart_modem_serial_pins DUT (
        .sys_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .irq_o, .tx_bit_a_i, .tx_active_a_i, .rx_has_data_a_i,
        .rx_above_trig_a_i, .rx_bit_a_o, .tx_hold_a_o, .tick16_a_o(),
        .tx_bit_b_i(b_bit), .tx_active_b_i(b_act), .rx_has_data_b_i(b_has),
        .rx_above_trig_b_i(b_trig), .rx_bit_b_o(), .tx_hold_b_o(),
        .tick16_b_o(), .serial_out_a_o, .serial_in_a_i,
        .request_to_send_n_a_o, .clear_to_send_n_a_i(ma_n[0]),
        .terminal_ready_n_a_o, .set_ready_n_a_i(ma_n[1]),
        .carrier_detect_n_a_i(ma_n[3]), .ring_indicator_n_a_i(ma_n[2]),
        .spare_output_n_a_o, .irq_out_a_o, .irq_out_a_oe_o, .rx_ready_n_a_o,
        .serial_out_b_o, .serial_in_b_i, .request_to_send_n_b_o(),
        .clear_to_send_n_b_i(mb_n[0]), .terminal_ready_n_b_o(),
        .set_ready_n_b_i(mb_n[1]), .carrier_detect_n_b_i(mb_n[3]),
        .ring_indicator_n_b_i(mb_n[2]), .spare_output_n_b_o,
        .irq_out_b_o(), .irq_out_b_oe_o, .rx_ready_n_b_o
    );
    line_partner pa (.sys_clk_i, .line_i(serial_out_a_o), .loop_i(loop_a),
        .lag_i(lag_a), .assert_i(ma), .line_o(serial_in_a_i),
        .modem_n_o(ma_n));
    line_partner pb (.sys_clk_i, .line_i(serial_out_b_o), .loop_i(1'b1),
        .lag_i(2'h1), .assert_i(4'h0), .line_o(serial_in_b_i),
        .modem_n_o(mb_n));

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        chk(rdata_o, e);
    endtask
    // Bounded wait on the transmit pin or the received bit of channel A
    task automatic seek(input bit rx, input logic v);
        for (int i = 0; i < 40; i++) begin
            if ((rx ? rx_bit_a_o : serial_out_a_o) === v) break;
            @(negedge sys_clk_i);
        end
        chk(rx ? rx_bit_a_o : serial_out_a_o, v);
    endtask
    task automatic done(input string s);
        $display("%s finished, %0d mismatches so far", s, n_errors);
    endtask
    task automatic tally_and_finish;
        $display("%0d comparisons, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic t_reset;
        repeat (5) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk({serial_out_a_o, serial_out_b_o, rx_ready_n_a_o}, 8'h07);
        chk({spare_output_n_a_o, irq_out_a_oe_o, irq_o}, 8'h04);
        @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        done("reset");
    endtask
    // Spare output is never driven as a free output here
    task automatic t_irq_pin;
        wr(4'h0, 8'h08);
        @(negedge sys_clk_i);
        chk({irq_out_a_oe_o, spare_output_n_a_o}, 8'h02);
        chk({irq_out_b_oe_o, spare_output_n_b_o}, 8'h01);
        rd(4'h0, 8'h08);
        wr(4'h8, 8'h08);
        wr(4'h0, 8'h00);
        @(negedge sys_clk_i);
        chk({irq_out_a_oe_o, spare_output_n_a_o}, 8'h01);
        chk({irq_out_b_oe_o, spare_output_n_b_o}, 8'h02);
        wr(4'h8, 8'h00);
        done("interrupt pin");
    endtask
    task automatic t_tx;
        @(posedge sys_clk_i);
        loop_a <= 1'b1;
        tx_active_a_i <= 1'b1;
        tx_bit_a_i <= 1'b0;
        settle(1);
        chk(serial_out_a_o, 1'b0);
        seek(1, 1'b0);
        @(posedge sys_clk_i);
        tx_active_a_i <= 1'b0;
        settle(1);
        chk(serial_out_a_o, 1'b1);
        seek(1, 1'b1);
        wr(4'h0, 8'h40);
        settle(1);
        chk(serial_out_a_o, 1'b0);
        @(posedge sys_clk_i);
        lag_a <= 2'h3;
        tx_active_a_i <= 1'b1;
        seek(0, 1'b1);
        seek(1, 1'b0);
        @(posedge sys_clk_i);
        tx_active_a_i <= 1'b0;
        settle(1);
        chk(serial_out_a_o, 1'b0);
        wr(4'h0, 8'h00);
        settle(1);
        chk(serial_out_a_o, 1'b1);
        done("transmit modes");
    endtask
    task automatic t_flow;
        wr(4'h0, 8'h03);
        settle(1);
        chk({terminal_ready_n_a_o, request_to_send_n_a_o}, 8'h00);
        wr(4'h1, 8'h40);
        @(posedge sys_clk_i);
        rx_above_trig_a_i <= 1'b1;
        settle(1);
        chk(request_to_send_n_a_o, 1'b1);
        @(posedge sys_clk_i);
        rx_above_trig_a_i <= 1'b0;
        wr(4'h1, 8'h80);
        wr(4'h0, 8'h00);
        settle(1);
        chk({terminal_ready_n_a_o, tx_hold_a_o}, 8'h03);
        @(posedge sys_clk_i);
        ma <= 4'h1;
        settle(4);
        chk(tx_hold_a_o, 1'b0);
        @(posedge sys_clk_i);
        ma <= 4'hf;
        settle(4);
        chk({tx_hold_a_o, serial_out_a_o}, 8'h01);
        rd(4'h3, 8'h0f);
        @(posedge sys_clk_i);
        ma <= 4'h0;
        settle(4);
        chk(tx_hold_a_o, 1'b1);
        wr(4'h1, 8'h00);
        settle(1);
        chk(tx_hold_a_o, 1'b0);
        done("flow control");
    endtask
    task automatic t_events;
        wr(4'h4, 8'h1f);
        rd(4'h4, 8'h00);
        @(posedge sys_clk_i);
        ma <= 4'h2;
        settle(5);
        chk({irq_o, irq_out_a_o}, 8'h03);
        rd(4'h4, 8'h02);
        rd(4'hc, 8'h00);
        wr(4'h5, 8'h02);
        settle(1);
        chk(irq_o, 1'b0);
        wr(4'h5, 8'h00);
        settle(1);
        chk(irq_o, 1'b1);
        wr(4'h4, 8'h02);
        settle(1);
        chk(irq_o, 1'b0);
        wr(4'h7, 8'hff);
        rd(4'h7, 8'h00);
        done("events");
    endtask
    task automatic t_rx_ready;
        @(posedge sys_clk_i);
        rx_has_data_a_i <= 1'b1;
        settle(1);
        chk({rx_ready_n_a_o, rx_ready_n_b_o}, 8'h01);
        @(posedge sys_clk_i);
        rx_has_data_a_i <= 1'b0;
        b_has <= 1'b1;
        settle(1);
        chk({rx_ready_n_a_o, rx_ready_n_b_o}, 8'h02);
        done("receiver ready");
    endtask

    initial begin
        {reset_n_i, wr_i, rd_i, tx_active_a_i, rx_has_data_a_i} = 5'h00;
        {rx_above_trig_a_i, b_act, b_has, b_trig, loop_a} = 5'h00;
        {tx_bit_a_i, b_bit} = 2'h3;
        lag_a = 2'h0;
        ma = 4'h0;
        addr_i = '0;
        wdata_i = '0;
        n_errors = 0;
        comparisons = 0;
        t_reset;
        t_irq_pin;
        t_tx;
        t_flow;
        t_events;
        t_rx_ready;
        tally_and_finish;
    end
    initial begin
        repeat (4000) @(posedge sys_clk_i);
        n_errors++;
        $display("watchdog expired");
        tally_and_finish;
    end
endmodule
